/* hw/debug_port_pkg.sv */
/*
  shared constants and types of the debug port: halt codes, packet
  length, scan instruction widths and the scan controller states.
  assumes nothing of its surroundings.
*/
package debug_port_pkg;
  // ----------------------------------------
  // halt indication
  // ----------------------------------------
  localparam logic [3:0] HALT_STATUS = 4'hF; // status nibble while halted
  localparam logic [7:0] HALT_TRACE = 8'h0F; // trace bus while halted
  // ----------------------------------------
  // serial packet
  // ----------------------------------------
  localparam int PKT_BITS = 17; // bits per packet
  localparam logic [4:0] PKT_LAST = 5'h10; // index of last bit
  localparam logic [4:0] CNT_ZERO = 5'h00; // counter start
  localparam logic [4:0] CNT_STEP = 5'h01; // counter increment
  // ----------------------------------------
  // scan instruction register
  // ----------------------------------------
  localparam int IR_BITS = 4; // instruction length
  localparam logic [3:0] IR_CAPTURE = 4'h1; // fixed capture pattern
  localparam logic [3:0] IR_RESET = 4'hF; // value in test-logic-reset
  // ----------------------------------------
  // scan controller states, gray along the data path
  // ----------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h3,
    TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6,
    TAP_EX1_DR = 4'h7,
    TAP_PAU_DR = 4'h5,
    TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hC,
    TAP_SEL_IR = 4'hD,
    TAP_CAP_IR = 4'hF,
    TAP_SH_IR = 4'hE,
    TAP_EX1_IR = 4'hA,
    TAP_PAU_IR = 4'hB,
    TAP_EX2_IR = 4'h9,
    TAP_UPD_IR = 4'h8
  } tap_state_e;
endpackage

/* hw/scan_tap.sv */
/*
  boundary-scan controller on the scan shift clock: sixteen-state
  sequencer, instruction and bypass shift paths, test data out.
  assumes tms and tdi are driven against the scan clock by the tester
  and that the mode level comes from the bus clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module scan_tap
  import debug_port_pkg::*;
(
  // scan pins
  input wire logic scan_shift_clock_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // mode from the bus clock domain
  input wire logic jtag_mode_i
);
  typedef struct packed {
    tap_state_e state; // sequencer state
    logic [IR_BITS-1:0] ir; // instruction shift path
    logic bypass; // one-bit data path
    logic mode1; // mode sync, first stage
    logic mode2; // mode sync, second stage
  } tap_s;
  tap_s st, next_st;
  logic shifting; // in a shift state; pin owned only in scan mode

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.mode1 = jtag_mode_i;
    next_st.mode2 = st.mode1;
    case (st.state) // tms steers every edge, see R3
      TAP_RESET: next_st.state = tms_i ? TAP_RESET : TAP_IDLE; // see R15
      TAP_IDLE: next_st.state = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_st.state = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_st.state = tms_i ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_st.state = tms_i ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_st.state = tms_i ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: next_st.state = tms_i ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: next_st.state = tms_i ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_st.state = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_st.state = tms_i ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_st.state = tms_i ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_st.state = tms_i ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_st.state = tms_i ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: next_st.state = tms_i ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: next_st.state = tms_i ? TAP_UPD_IR : TAP_SH_IR;
      default: next_st.state = tms_i ? TAP_SEL_DR : TAP_IDLE;
    endcase
    // shift paths take tdi on the rising edge, see R4
    case (st.state)
      TAP_RESET: next_st.ir = IR_RESET;
      TAP_CAP_IR: next_st.ir = IR_CAPTURE;
      TAP_SH_IR: next_st.ir = {tdi_i, st.ir[IR_BITS-1:1]}; // see R4
      TAP_CAP_DR: next_st.bypass = 1'b0;
      TAP_SH_DR: next_st.bypass = tdi_i; // see R4
      default: next_st.ir = st.ir;
    endcase
  end

  // ----------------------------------------
  // rising edge register, trst needs no clock
  // ----------------------------------------
  always_ff @(posedge scan_shift_clock_i or negedge trst_n_i) begin
    if (!trst_n_i) begin // see R2
      st <= '{TAP_RESET, IR_RESET, 1'b0, 1'b0, 1'b0}; // see R15
    end else begin
      st <= next_st;
    end
  end

  assign shifting = (st.state == TAP_SH_IR) || (st.state == TAP_SH_DR);

  // ----------------------------------------
  // tdo on the falling edge, half a cycle of setup for the tester
  // ----------------------------------------
  always_ff @(negedge scan_shift_clock_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o <= (st.state == TAP_SH_IR) ? st.ir[0] : st.bypass; // see R6
      tdo_oe_o <= shifting && st.mode2; // see R5
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_tms_to_reset: assert property (@(posedge scan_shift_clock_i) // see R3
    disable iff (!trst_n_i) tms_i [*5] |=> st.state == TAP_RESET)
    else $error("five tms highs did not reach reset");
  a_reset_exit: assert property (@(posedge scan_shift_clock_i) // see R15
    disable iff (!trst_n_i) (st.state == TAP_RESET && !tms_i) |=> st.state == TAP_IDLE)
    else $error("reset state did not go idle");
  a_ir_takes_tdi: assert property (@(posedge scan_shift_clock_i) // see R4
    disable iff (!trst_n_i) st.state == TAP_SH_IR |=> st.ir[IR_BITS-1] == $past(tdi_i))
    else $error("instruction shift lost tdi");
  a_tdo_enable: assert property (@(posedge scan_shift_clock_i) // see R5
    disable iff (!trst_n_i) tdo_oe_o == (shifting && st.mode2))
    else $error("tdo enable outside shift states");
  a_tdo_value: assert property (@(posedge scan_shift_clock_i) // see R6
    disable iff (!trst_n_i) (st.state == TAP_SH_IR && tdo_oe_o) |-> tdo_o == st.ir[0])
    else $error("tdo not updated on falling edge");
  c_shift_ir: cover property (@(posedge scan_shift_clock_i)
    disable iff (!trst_n_i) st.state == TAP_SH_IR ##1 st.state == TAP_EX1_IR);
endmodule // scan_tap
`default_nettype wire

/* hw/debug_port.sv */
/*
  pin-level debug port: mode strap, background debug serial link,
  breakpoint request and halt status, with the scan controller inside.
  assumes the core gives instruction-done, status and reply words on
  the bus clock; scan and debug pins arrive asynchronous to it.
*/
// Contract
// R1: select strap at reset picks scan or serial
// R2: trst low resets scan logic asynchronously
// R3: tms sampled on scan clock rise
// R4: tdi sampled on scan clock rise
// R5: tdo driven only in shift states
// R6: tdo updates on scan clock fall
// R7: serial clock accepted after two equal samples
// R8: debugger keeps serial clock below status/5
// R9: validated rise samples input, advances output
// R10: breakpoint halts after current instruction
// R11: halted shows 0xF on status outputs
// R12: disable bit turns breakpoint into interrupt
// R13: serial output registered, after validated high
// R14: serial input synchronised, taken after high
// R15: sixteen-state scan sequencer, reset on trst
// R16: serial output steady between validated rises
`timescale 1ns/100ps
`default_nettype none
module debug_port
  import debug_port_pkg::*;
(
  // system
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // strap
  input wire logic jtag_enable_i,
  output logic jtag_mode_o,
  // scan pins
  input wire logic scan_shift_clock_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // serial debug pins
  input wire logic debug_serial_clock_i,
  input wire logic debug_serial_in_i,
  output logic debug_serial_out_o,
  // packet words to and from the debug core
  input wire logic [PKT_BITS-1:0] tx_word_i,
  output logic [PKT_BITS-1:0] rx_word_o,
  output logic rx_strobe_o,
  // breakpoint
  input wire logic breakpoint_request_pin_i,
  input wire logic breakpoint_disable_bit_i,
  input wire logic insn_done_i,
  input wire logic resume_i,
  output logic halt_o,
  output logic debug_irq_o,
  // status outputs
  input wire logic [3:0] core_status_i,
  input wire logic [7:0] trace_data_i,
  output logic [3:0] core_status_outputs_o,
  output logic [7:0] status_and_trace_bus_o
);
  typedef struct packed {
    logic sel1; // strap sync, first stage
    logic sel2; // strap sync, second stage
    logic [1:0] sel_age; // edges seen since release
    logic sel_done; // strap captured
    logic jtag_mode; // 1 scan, 0 serial
    logic sc1; // serial clock sync, first stage
    logic sc2; // serial clock sync, second stage
    logic sc3; // previous sample for validation
    logic sclk_lvl; // validated serial clock level
    logic di1; // serial input sync, first stage
    logic di2; // serial input sync, second stage
    logic [PKT_BITS-1:0] shreg; // packet shift path
    logic [4:0] bitcnt; // bit index in packet
    logic dout; // serial output register
    logic [PKT_BITS-1:0] rx_word; // last received packet
    logic rx_strobe; // one-cycle packet pulse
    logic br1; // breakpoint sync, first stage
    logic br2; // breakpoint sync, second stage
    logic br3; // edge detect
    logic brk_pending; // request waiting for instruction end
    logic halted; // core halted
    logic dbg_irq; // one-cycle interrupt pulse
    logic [3:0] status; // status nibble out
    logic [7:0] trace; // trace bus out
  } top_s;
  top_s st, next_st;
  logic sclk_ok; // two samples agree
  logic sclk_rise; // validated rising edge
  logic serial_on; // serial personality active
  logic brk_req; // fresh breakpoint assertion
  logic brk_take; // pending request meets instruction end
  logic halt_set; // halt this cycle

  // ----------------------------------------
  // decoded events
  // ----------------------------------------
  always_comb begin
    sclk_ok = st.sc2 == st.sc3; // see R7
    sclk_rise = sclk_ok && st.sc2 && !st.sclk_lvl; // see R7
    serial_on = st.sel_done && !st.jtag_mode;
    brk_req = st.br2 && !st.br3;
    brk_take = st.brk_pending && insn_done_i; // see R10
    halt_set = brk_take && !breakpoint_disable_bit_i;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // strap caught on the third edge after release, then frozen, see R1
    next_st.sel1 = jtag_enable_i;
    next_st.sel2 = st.sel1;
    next_st.sel_age = {st.sel_age[0], 1'b1};
    if (st.sel_age[1] && !st.sel_done) begin // see R1
      next_st.jtag_mode = st.sel2;
      next_st.sel_done = 1'b1;
    end
    // serial clock and input synchronisers
    next_st.sc1 = debug_serial_clock_i;
    next_st.sc2 = st.sc1;
    next_st.sc3 = st.sc2;
    if (sclk_ok) begin // level changes only once confirmed, see R7
      next_st.sclk_lvl = st.sc2;
    end
    next_st.di1 = debug_serial_in_i; // see R14
    next_st.di2 = st.di1;
    // packet shifting on validated rises only, see R9
    next_st.rx_strobe = 1'b0;
    if (sclk_rise && serial_on) begin // see R13
      next_st.shreg = {st.shreg[PKT_BITS-2:0], st.di2}; // see R14
      next_st.dout = st.shreg[PKT_BITS-1]; // see R9
      if (st.bitcnt == PKT_LAST) begin
        // full packet: hand it over, load the reply
        next_st.bitcnt = CNT_ZERO;
        next_st.rx_word = {st.shreg[PKT_BITS-2:0], st.di2};
        next_st.rx_strobe = 1'b1;
        next_st.shreg = tx_word_i;
      end else begin
        next_st.bitcnt = st.bitcnt + CNT_STEP;
      end
    end
    // otherwise dout holds, see R16
    // breakpoint: new request wins over the consume of an old one
    next_st.br1 = breakpoint_request_pin_i;
    next_st.br2 = st.br1;
    next_st.br3 = st.br2;
    next_st.brk_pending = (st.brk_pending && !brk_take) || (brk_req && !st.halted);
    next_st.dbg_irq = brk_take && breakpoint_disable_bit_i; // see R12
    next_st.halted = halt_set || (st.halted && !resume_i); // see R10
    // halt code tracks the halt flag in the same cycle, see R11
    next_st.status = next_st.halted ? HALT_STATUS : core_status_i;
    next_st.trace = next_st.halted ? HALT_TRACE : trace_data_i;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign jtag_mode_o = st.jtag_mode;
  assign debug_serial_out_o = st.dout; // see R13
  assign rx_word_o = st.rx_word;
  assign rx_strobe_o = st.rx_strobe;
  assign halt_o = st.halted;
  assign debug_irq_o = st.dbg_irq;
  assign core_status_outputs_o = st.status;
  assign status_and_trace_bus_o = st.trace;

  // ----------------------------------------
  // scan controller, runs on its own clock
  // ----------------------------------------
  // mode is a quasi-static level, synchronised inside the controller
  scan_tap u_tap (
    .scan_shift_clock_i(scan_shift_clock_i),
    .trst_n_i(trst_n_i),
    .tms_i(tms_i),
    .tdi_i(tdi_i),
    .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o),
    .jtag_mode_i(st.jtag_mode)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_strap_frozen: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R1
    st.sel_done |=> st.sel_done && $stable(st.jtag_mode))
    else $error("mode changed after strap capture");
  a_sclk_two_equal: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R7
    $changed(st.sclk_lvl) |-> $past(st.sc2) == st.sclk_lvl && $past(st.sc3) == st.sclk_lvl)
    else $error("serial clock level taken without two samples");
  a_dout_advance: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R9
    (sclk_rise && serial_on) |=> st.dout == $past(st.shreg[PKT_BITS-1]))
    else $error("serial output did not advance");
  a_dout_steady: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R16
    !(sclk_rise && serial_on) |=> $stable(st.dout))
    else $error("serial output moved between rises");
  a_din_taken: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R14
    (sclk_rise && serial_on && st.bitcnt != PKT_LAST) |=> st.shreg[0] == $past(st.di2))
    else $error("serial input not shifted in");
  a_halt_after_insn: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R10
    (st.brk_pending && !insn_done_i && !st.halted) |=> !st.halted)
    else $error("halt before instruction completed");
  a_halt_take: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R10
    (brk_take && !breakpoint_disable_bit_i) |=> st.halted && !st.dbg_irq)
    else $error("breakpoint did not halt");
  a_halt_code: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R11
    st.halted |-> st.status == HALT_STATUS && st.trace == HALT_TRACE)
    else $error("halt code missing on status outputs");
  a_irq_instead: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see R12
    (brk_take && breakpoint_disable_bit_i && !st.halted) |=> st.dbg_irq && !st.halted)
    else $error("disabled breakpoint did not raise interrupt");
  c_packet: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) st.rx_strobe);
  c_halt: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) $rose(st.halted));
  c_irq: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) st.dbg_irq);
endmodule // debug_port
`default_nettype wire

/* tb/debug_host_model.sv */
/*
  debugger and scan tester at the far side of the debug pins.
  assumes one caller at a time; the bus clock paces the serial clock.
*/
`timescale 1ns/100ps
`default_nettype none
module debug_host_model (
  // pacing clock
  input wire logic clk_sys_i,
  // scan pins
  output logic scan_shift_clock_o,
  output logic trst_n_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  // serial debug pins
  output logic debug_serial_clock_o,
  output logic debug_serial_in_o,
  input wire logic debug_serial_out_i
);
  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  wire logic tdo_pin; // no pull on the line: shows the inverse when let go
  assign tdo_pin = tdo_oe_i ? tdo_i : ~tdo_i;
  // clocks stand low outside frames
  initial begin
    scan_shift_clock_o = 1'b0;
    trst_n_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    debug_serial_clock_o = 1'b0;
    debug_serial_in_o = 1'b0;
  end
  // ----------------------------------------
  // scan side
  // ----------------------------------------
  // one 6 ns scan clock period; tdo read just before the next rise
  task automatic scan_bit(input logic tms, input logic tdi, output logic oe, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #1 scan_shift_clock_o = 1'b1;
    #3 scan_shift_clock_o = 1'b0;
    #2 oe = tdo_oe_i;
    tdo = tdo_pin;
  endtask
  // test reset level
  task automatic set_trst(input logic v);
    trst_n_o = v;
  endtask
  // data line after a frame no longer shows the last bit
  task automatic scan_release;
    tdi_o = ~tdi_o;
  endtask
  // ----------------------------------------
  // serial side
  // ----------------------------------------
  // 8 cycle halves keep the clock far below a fifth of status rate
  task automatic ser_bit(input logic din, output logic dout);
    debug_serial_in_o = din;
    repeat (8) @(posedge clk_sys_i);
    #1 debug_serial_clock_o = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1 dout = debug_serial_out_i;
    debug_serial_clock_o = 1'b0;
  endtask
  // data line after a packet no longer shows the last bit
  task automatic ser_release;
    debug_serial_in_o = ~debug_serial_in_o;
  endtask
endmodule // debug_host_model
`default_nettype wire

/* tb/testbench.sv */
/*
  self-checking bench of the debug port: serial packets, breakpoint,
  scan controller walks in both strap modes.
  assumes debug_port_pkg and the far-side model debug_host_model.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import debug_port_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys_i = 1'b0;
  logic nrst_i, jtag_enable_i, jmode, sclk, trst_n, tms, tdi, tdo, tdo_oe;
  logic debug_serial_clock, dsi, debug_serial_out, rx_strobe, bp, bkd, insn_done, resume, halt, dirq;
  logic [16:0] tx_word, rx_word;
  logic [3:0] cst, cso;
  logic [7:0] trd, tso;
  logic [16:0] got_q[$]; // received words in order
  int n_fail = 0;
  int checked = 0;
  always #10 clk_sys_i = ~clk_sys_i; // 50 MHz
  // strobe stands one cycle, so catch it at every edge
  always @(posedge clk_sys_i) if (rx_strobe === 1'b1) got_q.push_back(rx_word);
  debug_port dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .jtag_enable_i(jtag_enable_i),
    .jtag_mode_o(jmode), .scan_shift_clock_i(sclk), .trst_n_i(trst_n), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .debug_serial_clock_i(debug_serial_clock),
    .debug_serial_in_i(dsi), .debug_serial_out_o(debug_serial_out), .tx_word_i(tx_word),
    .rx_word_o(rx_word), .rx_strobe_o(rx_strobe), .breakpoint_request_pin_i(bp),
    .breakpoint_disable_bit_i(bkd), .insn_done_i(insn_done), .resume_i(resume),
    .halt_o(halt), .debug_irq_o(dirq), .core_status_i(cst), .trace_data_i(trd),
    .core_status_outputs_o(cso), .status_and_trace_bus_o(tso));
  debug_host_model host (.clk_sys_i(clk_sys_i), .scan_shift_clock_o(sclk),
    .trst_n_o(trst_n), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe),
    .debug_serial_clock_o(debug_serial_clock), .debug_serial_in_o(dsi), .debug_serial_out_i(debug_serial_out));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // strap held through reset and capture
  task automatic do_reset(input logic strap);
    nrst_i = 1'b0;
    jtag_enable_i = strap;
    cyc(12);
    nrst_i = 1'b1;
    cyc(6);
  endtask
  // msb first both ways
  task automatic ser_packet(input logic [16:0] w, output logic [16:0] reply);
    logic b;
    for (int i = 16; i >= 0; i--) begin
      host.ser_bit(w[i], b);
      reply[i] = b;
    end
    host.ser_release;
  endtask
  task automatic sbit(input logic m, input logic t, input logic eoe, input logic etdo);
    logic oe, o;
    host.scan_bit(m, t, oe, o);
    chk_bit("tdo_oe", eoe, oe);
    if (eoe) chk_bit("tdo", etdo, o);
  endtask
  // from reset: idle, select-dr, select-ir, capture-ir, shift-ir
  task automatic to_shift_ir(input logic sm);
    sbit(1'b0, 1'b0, 1'b0, 1'b0);
    sbit(1'b1, 1'b0, 1'b0, 1'b0);
    sbit(1'b1, 1'b0, 1'b0, 1'b0);
    sbit(1'b0, 1'b0, 1'b0, 1'b0);
    sbit(1'b0, 1'b0, sm, 1'b1); // capture lsb first
  endtask
  task automatic scan_walk(input logic sm);
    logic [7:0] r;
    r = 8'($urandom);
    host.set_trst(1'b0);
    #5;
    chk_bit("tdo_oe", 1'b0, tdo_oe);
    host.set_trst(1'b1);
    #5;
    to_shift_ir(sm);
    for (int i = 0; i < 3; i++) sbit(1'b0, r[i], sm, 1'b0);
    sbit(1'b1, r[3], 1'b0, 1'b0); // exit releases tdo
    sbit(1'b1, 1'b0, 1'b0, 1'b0);
    sbit(1'b1, 1'b0, 1'b0, 1'b0);
    sbit(1'b0, 1'b0, 1'b0, 1'b0);
    sbit(1'b0, 1'b0, sm, 1'b0); // bypass captures zero
    for (int i = 0; i < 8; i++) sbit(1'b0, r[i], sm, r[i]);
    for (int i = 0; i < 5; i++) sbit(1'b1, 1'b0, 1'b0, 1'b0);
    to_shift_ir(sm); // five highs reached reset
    host.set_trst(1'b0);
    #2;
    chk_bit("tdo_oe", 1'b0, tdo_oe);
    host.set_trst(1'b1);
    host.scan_release;
  endtask
  task automatic end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // watchdog, well beyond the twelve hundred or so cycles the tests need
  // ----------------------------------------
  initial begin
    #(20 * 40000);
    n_fail++;
    $display("watchdog expired");
    end_of_test;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [16:0] w, seen, exp_reply;
    int irqs;
    void'($urandom(32'hA64C));
    {bp, bkd, insn_done, resume} = '0;
    {tx_word, cst, trd} = '0;
    do_reset(1'b0);
    chk_bit("jtag_mode", 1'b0, jmode);
    exp_reply = '0;
    for (int p = 0; p < 3; p++) begin
      w = 17'($urandom);
      tx_word = 17'($urandom);
      ser_packet(w, seen);
      cyc(2);
      chk_word("reply", exp_reply, seen);
      chk_word("rx_count", 17'h00001, 17'(got_q.size()));
      if (got_q.size() > 0) chk_word("rx_word", w, got_q.pop_front());
      exp_reply = tx_word;
    end
    scan_walk(1'b0);
    $display("test serial mode done");
    cst = 4'($urandom) & 4'h7;
    trd = 8'($urandom) | 8'h80;
    bp = 1'b1;
    cyc(6);
    chk_bit("halt", 1'b0, halt);
    insn_done = 1'b1;
    cyc(1);
    insn_done = 1'b0;
    cyc(1);
    chk_bit("halt", 1'b1, halt);
    chk_word("status", 17'(HALT_STATUS), 17'(cso));
    chk_word("trace", 17'(HALT_TRACE), 17'(tso));
    bp = 1'b0;
    cyc(3);
    bp = 1'b1; // dropped while halted
    cyc(6);
    resume = 1'b1;
    cyc(1);
    resume = 1'b0;
    insn_done = 1'b1;
    cyc(4);
    insn_done = 1'b0;
    chk_bit("halt", 1'b0, halt);
    chk_word("status", 17'(cst), 17'(cso));
    chk_word("trace", 17'(trd), 17'(tso));
    bp = 1'b0;
    bkd = 1'b1;
    cyc(3);
    bp = 1'b1;
    cyc(6);
    insn_done = 1'b1;
    irqs = 0;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      insn_done = 1'b0;
      irqs = irqs + int'(dirq === 1'b1);
    end
    chk_word("irq_count", 17'h00001, 17'(irqs));
    chk_bit("halt", 1'b0, halt);
    bp = 1'b0;
    bkd = 1'b0;
    $display("test breakpoint done");
    do_reset(1'b1);
    chk_bit("jtag_mode", 1'b1, jmode);
    scan_walk(1'b1);
    ser_packet(17'($urandom), seen);
    cyc(6);
    chk_word("reply_scan", 17'h00000, seen);
    chk_word("rx_count", 17'h00000, 17'(got_q.size()));
    $display("test scan mode done");
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
